// File: verilog/image_window_regs.sv
// Function
// - Statistics window restricts pixels for exposure, gain, white balance, lookup table.
// - Four-bit window mode: off, include/exclude for all, AE/AG, WB, LOOKUP_TABLE.
// - Two-bit subsampling mode: off, x, y, both.
// - Two-bit averaging mode: off, x, y, both.
// - Bit 0 of dark calibration control enables automatic dark calibration.
// - Black-level offset, sign-magnitude, applied only with calibration disabled.
// - Analog gain codes select 1.0x, 1.26x, 1.87x, 3.17x.
// - Digital gain codes below 1024 unused; above apply 0.00097x per step.
// - Digital offset is 10-bit sign-magnitude, -511 to +511.
//
// Local design decision: the AHB-Lite slave port.
module image_window_regs (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pixel stream
    input wire logic pix_valid,
    input wire logic [11:0] pix_in,
    output logic pix_out_valid,
    output logic [11:0] pix_out,
    // Configuration to the pipeline
    output pix_regs_pkg::cfg_type cfg,
    output pix_regs_pkg::win_sel_type win_sel,
    output pix_regs_pkg::decim_type decim,
    output logic [9:0] analog_gain_q8,
    output logic digital_gain_valid,
    output logic [13:0] digital_gain_steps
);
    pix_regs_pkg::cfg_type cfg_reg;
    pix_regs_pkg::cfg_type cfg_next;
    logic wr_pend_reg;
    logic [11:0] wr_addr_reg;
    logic [31:0] rd_word;
    logic take;

    assign take = hsel && hready && htrans[1];
    // Writes land in one cycle, reads come straight from the stores
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else if (hready) begin
            wr_pend_reg <= take && hwrite;
            wr_addr_reg <= haddr[11:0];
        end
    end

    // Pending write merged here so a read issued in the write's data phase sees it
    always_comb begin
        cfg_next = cfg_reg;
        if (wr_pend_reg) begin
            unique case (wr_addr_reg)
                pix_regs_pkg::OFF_VWIN_OFFSET: cfg_next.v_offset = hwdata[11:0];
                pix_regs_pkg::OFF_VWIN_SIZE: cfg_next.v_size = hwdata[11:0];
                pix_regs_pkg::OFF_SWIN_VOFFSET: cfg_next.sw_voffset = hwdata[12:0];
                pix_regs_pkg::OFF_SWIN_VSIZE: cfg_next.sw_vsize = hwdata[12:0];
                pix_regs_pkg::OFF_SWIN_HOFFSET: cfg_next.sw_hoffset = hwdata[12:0];
                pix_regs_pkg::OFF_SWIN_HSIZE: cfg_next.sw_hsize = hwdata[12:0];
                pix_regs_pkg::OFF_SWIN_MODE: cfg_next.sw_mode = hwdata[3:0];
                pix_regs_pkg::OFF_DGAIN: cfg_next.digital_gain = hwdata[13:0];
                pix_regs_pkg::OFF_DOFFSET: cfg_next.digital_offset = hwdata[9:0];
                pix_regs_pkg::OFF_SUBSAMPLE: cfg_next.subsample = hwdata[1:0];
                pix_regs_pkg::OFF_AGAIN: cfg_next.analog_gain = hwdata[1:0];
                pix_regs_pkg::OFF_AVERAGE: cfg_next.average = hwdata[1:0];
                pix_regs_pkg::OFF_DARK_CAL: cfg_next.dark_cal_en = hwdata[0];
                pix_regs_pkg::OFF_DARK_OFFSET: cfg_next.dark_offset = hwdata[9:0];
                default: ;
            endcase
        end
    end

    // Only the low field bits are stored, so upper bits drop on write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_reg.v_offset <= pix_regs_pkg::RST_VWIN_OFFSET;
            cfg_reg.v_size <= pix_regs_pkg::RST_VWIN_SIZE;
            cfg_reg.sw_hoffset <= pix_regs_pkg::RST_SWIN_OFFSET;
            cfg_reg.sw_hsize <= pix_regs_pkg::RST_SWIN_HSIZE;
            cfg_reg.sw_voffset <= pix_regs_pkg::RST_SWIN_OFFSET;
            cfg_reg.sw_vsize <= pix_regs_pkg::RST_SWIN_VSIZE;
            cfg_reg.sw_mode <= pix_regs_pkg::RST_SWIN_MODE;
            cfg_reg.subsample <= pix_regs_pkg::RST_TWO_BIT;
            cfg_reg.average <= pix_regs_pkg::RST_TWO_BIT;
            cfg_reg.dark_cal_en <= pix_regs_pkg::RST_DARK_CAL;
            cfg_reg.dark_offset <= pix_regs_pkg::RST_OFS;
            cfg_reg.analog_gain <= pix_regs_pkg::RST_TWO_BIT;
            cfg_reg.digital_gain <= pix_regs_pkg::RST_DGAIN;
            cfg_reg.digital_offset <= pix_regs_pkg::RST_OFS;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // Read mux zero-extends every field; unmapped words read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (haddr[11:0])
            pix_regs_pkg::OFF_VWIN_OFFSET: rd_word = {20'h00000, cfg_next.v_offset};
            pix_regs_pkg::OFF_VWIN_SIZE: rd_word = {20'h00000, cfg_next.v_size};
            pix_regs_pkg::OFF_SWIN_VOFFSET: rd_word = {19'h00000, cfg_next.sw_voffset};
            pix_regs_pkg::OFF_SWIN_VSIZE: rd_word = {19'h00000, cfg_next.sw_vsize};
            pix_regs_pkg::OFF_SWIN_HOFFSET: rd_word = {19'h00000, cfg_next.sw_hoffset};
            pix_regs_pkg::OFF_SWIN_HSIZE: rd_word = {19'h00000, cfg_next.sw_hsize};
            pix_regs_pkg::OFF_SWIN_MODE: rd_word = {28'h0000000, cfg_next.sw_mode};
            pix_regs_pkg::OFF_DGAIN: rd_word = {18'h00000, cfg_next.digital_gain};
            pix_regs_pkg::OFF_DOFFSET: rd_word = {22'h000000, cfg_next.digital_offset};
            pix_regs_pkg::OFF_SUBSAMPLE: rd_word = {30'h00000000, cfg_next.subsample};
            pix_regs_pkg::OFF_AGAIN: rd_word = {30'h00000000, cfg_next.analog_gain};
            pix_regs_pkg::OFF_AVERAGE: rd_word = {30'h00000000, cfg_next.average};
            pix_regs_pkg::OFF_DARK_CAL: rd_word = {31'h00000000, cfg_next.dark_cal_en};
            pix_regs_pkg::OFF_DARK_OFFSET: rd_word = {22'h000000, cfg_next.dark_offset};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Data phase of a read follows the address phase by one edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= rd_word;
        end
    end

    assign cfg = cfg_reg;

    win_mode_decode u_win_mode_decode (
        .mode(cfg_reg.sw_mode),
        .sel(win_sel)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            decim <= '0;
        end else begin
            decim.sub_x <= cfg_reg.subsample[0];
            decim.sub_y <= cfg_reg.subsample[1];
            decim.avg_x <= cfg_reg.average[0];
            decim.avg_y <= cfg_reg.average[1];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_gain_q8 <= pix_regs_pkg::AGAIN_X1;
        end else begin
            unique case (cfg_reg.analog_gain)
                2'h0: analog_gain_q8 <= pix_regs_pkg::AGAIN_X1;
                2'h1: analog_gain_q8 <= pix_regs_pkg::AGAIN_X126;
                2'h2: analog_gain_q8 <= pix_regs_pkg::AGAIN_X187;
                2'h3: analog_gain_q8 <= pix_regs_pkg::AGAIN_X317;
            endcase
        end
    end

    // Codes under the unity code are flagged unusable rather than applied
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            digital_gain_valid <= 1'b1;
            digital_gain_steps <= 14'h0000;
        end else begin
            digital_gain_valid <= cfg_reg.digital_gain >= pix_regs_pkg::DGAIN_MIN;
            if (cfg_reg.digital_gain >= pix_regs_pkg::DGAIN_MIN) begin
                digital_gain_steps <= cfg_reg.digital_gain - pix_regs_pkg::DGAIN_MIN;
            end else begin
                digital_gain_steps <= 14'h0000;
            end
        end
    end

    pixel_correct u_pixel_correct (
        .hclk(hclk),
        .hresetn(hresetn),
        .dark_cal_en(cfg_reg.dark_cal_en),
        .dark_offset(cfg_reg.dark_offset),
        .digital_offset(cfg_reg.digital_offset),
        .pix_valid(pix_valid),
        .pix_in(pix_in),
        .pix_out_valid(pix_out_valid),
        .pix_out(pix_out)
    );
endmodule

// File: verilog/pix_regs_pkg.sv
package pix_regs_pkg;

    // Byte offsets of the register words
    localparam logic [11:0] OFF_VWIN_OFFSET = 12'h000;
    localparam logic [11:0] OFF_VWIN_SIZE = 12'h004;
    localparam logic [11:0] OFF_SWIN_VOFFSET = 12'h010;
    localparam logic [11:0] OFF_SWIN_VSIZE = 12'h014;
    localparam logic [11:0] OFF_SWIN_HOFFSET = 12'h018;
    localparam logic [11:0] OFF_SWIN_HSIZE = 12'h01C;
    localparam logic [11:0] OFF_SWIN_MODE = 12'h020;
    localparam logic [11:0] OFF_DGAIN = 12'h438;
    localparam logic [11:0] OFF_DOFFSET = 12'h43C;
    localparam logic [11:0] OFF_SUBSAMPLE = 12'h73C;
    localparam logic [11:0] OFF_AGAIN = 12'h748;
    localparam logic [11:0] OFF_AVERAGE = 12'h754;
    localparam logic [11:0] OFF_DARK_CAL = 12'h758;
    localparam logic [11:0] OFF_DARK_OFFSET = 12'h75C;

    // Field widths
    localparam int VWIN_W = 12;
    localparam int SWIN_W = 13;
    localparam int MODE_W = 4;
    localparam int DGAIN_W = 14;
    localparam int OFS_W = 10;

    // Reset values
    localparam logic [11:0] RST_VWIN_OFFSET = 12'h000;
    localparam logic [11:0] RST_VWIN_SIZE = 12'h002;
    localparam logic [12:0] RST_SWIN_OFFSET = 13'h0000;
    localparam logic [12:0] RST_SWIN_HSIZE = 13'h0008;
    localparam logic [12:0] RST_SWIN_VSIZE = 13'h0002;
    localparam logic [3:0] RST_SWIN_MODE = 4'h0;
    localparam logic [13:0] RST_DGAIN = 14'h0400;
    localparam logic [9:0] RST_OFS = 10'h000;
    localparam logic [1:0] RST_TWO_BIT = 2'h0;
    localparam logic RST_DARK_CAL = 1'b0;

    // Lowest digital gain code that has effect (unity)
    localparam logic [13:0] DGAIN_MIN = 14'h0400;

    // Analog gain steps in 1/256 units: 1.0, 1.26, 1.87, 3.17
    localparam logic [9:0] AGAIN_X1 = 10'h100;
    localparam logic [9:0] AGAIN_X126 = 10'h143;
    localparam logic [9:0] AGAIN_X187 = 10'h1DF;
    localparam logic [9:0] AGAIN_X317 = 10'h32B;

    typedef enum logic [3:0] {
        WIN_OFF = 4'h0,
        WIN_ALL_IN = 4'h1,
        WIN_ALL_EX = 4'h2,
        WIN_AE_IN = 4'h3,
        WIN_AE_EX = 4'h4,
        WIN_WB_IN = 4'h5,
        WIN_WB_EX = 4'h6,
        WIN_LUT_IN = 4'h7,
        WIN_LUT_EX = 4'h8
    } win_mode_type;

    // Per-function window qualifiers
    typedef struct packed {
        logic ae_use;
        logic ae_excl;
        logic wb_use;
        logic wb_excl;
        logic lut_use;
        logic lut_excl;
    } win_sel_type;

    typedef struct packed {
        logic [11:0] v_offset;
        logic [11:0] v_size;
        logic [12:0] sw_hoffset;
        logic [12:0] sw_hsize;
        logic [12:0] sw_voffset;
        logic [12:0] sw_vsize;
        logic [3:0] sw_mode;
        logic [1:0] subsample;
        logic [1:0] average;
        logic dark_cal_en;
        logic [9:0] dark_offset;
        logic [1:0] analog_gain;
        logic [13:0] digital_gain;
        logic [9:0] digital_offset;
    } cfg_type;

    typedef struct packed {
        logic sub_x;
        logic sub_y;
        logic avg_x;
        logic avg_y;
    } decim_type;

endpackage

// File: verilog/win_mode_decode.sv
module win_mode_decode (
    // Programmed mode
    input wire logic [3:0] mode,
    // Per-function selection
    output pix_regs_pkg::win_sel_type sel
);
    always_comb begin
        sel = '0;
        unique case (mode)
            pix_regs_pkg::WIN_OFF: sel = '0;
            pix_regs_pkg::WIN_ALL_IN: sel = 6'b10_10_10;
            pix_regs_pkg::WIN_ALL_EX: sel = 6'b11_11_11;
            pix_regs_pkg::WIN_AE_IN: sel.ae_use = 1'b1;
            pix_regs_pkg::WIN_AE_EX: sel = 6'b11_00_00;
            pix_regs_pkg::WIN_WB_IN: sel.wb_use = 1'b1;
            pix_regs_pkg::WIN_WB_EX: sel = 6'b00_11_00;
            pix_regs_pkg::WIN_LUT_IN: sel.lut_use = 1'b1;
            pix_regs_pkg::WIN_LUT_EX: sel = 6'b00_00_11;
            // Codes 9 to 15 are undefined and leave the window off
            default: sel = '0;
        endcase
    end
endmodule

// File: verilog/pixel_correct.sv
module pixel_correct (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Settings
    input wire logic dark_cal_en,
    input wire logic [9:0] dark_offset,
    input wire logic [9:0] digital_offset,
    // Pixel stream
    input wire logic pix_valid,
    input wire logic [11:0] pix_in,
    output logic pix_out_valid,
    output logic [11:0] pix_out
);
    logic [13:0] sum;

    // Both offsets are sign-magnitude; the manual one only acts with calibration off
    always_comb begin
        sum = {2'b00, pix_in};
        if (!dark_cal_en) begin
            if (dark_offset[9]) begin
                sum = sum - {5'h00, dark_offset[8:0]};
            end else begin
                sum = sum + {5'h00, dark_offset[8:0]};
            end
        end
        if (digital_offset[9]) begin
            sum = sum - {5'h00, digital_offset[8:0]};
        end else begin
            sum = sum + {5'h00, digital_offset[8:0]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pix_out_valid <= 1'b0;
        end else begin
            pix_out_valid <= pix_valid;
        end
    end

    // Clamp to the pixel range; underflow wraps into the top bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pix_out <= 12'h000;
        end else if (pix_valid) begin
            if (sum[13]) begin
                pix_out <= 12'h000;
            end else if (sum[12]) begin
                pix_out <= 12'hFFF;
            end else begin
                pix_out <= sum[11:0];
            end
        end
    end
endmodule

// File: dv/image_window_regs_sva.sv
module image_window_regs_sva (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Pixel stream
    input wire logic pix_valid,
    input wire logic [11:0] pix_in,
    input wire logic pix_out_valid,
    input wire logic [11:0] pix_out,
    // Configuration
    input wire pix_regs_pkg::cfg_type cfg,
    input wire pix_regs_pkg::win_sel_type win_sel,
    input wire pix_regs_pkg::decim_type decim,
    input wire logic [9:0] analog_gain_q8,
    input wire logic digital_gain_valid,
    input wire logic [13:0] digital_gain_steps
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    function automatic logic [5:0] sel_of(logic [3:0] m);
        case (m)
            4'h1: return 6'h2A;
            4'h2: return 6'h3F;
            4'h3: return 6'h20;
            4'h4: return 6'h30;
            4'h5: return 6'h08;
            4'h6: return 6'h0C;
            4'h7: return 6'h02;
            4'h8: return 6'h03;
            default: return 6'h00;
        endcase
    endfunction
    function automatic logic [9:0] q8_of(logic [1:0] c);
        return c == 2'h0 ? 10'h100 : c == 2'h1 ? 10'h143 : c == 2'h2 ? 10'h1DF : 10'h32B;
    endfunction
    function automatic int sm(logic [9:0] v);
        return v[9] ? -int'(v[8:0]) : int'(v[8:0]);
    endfunction
    function automatic logic [11:0] pix_of(logic [11:0] p, pix_regs_pkg::cfg_type c);
        int v;
        v = int'(p) + sm(c.digital_offset) + (c.dark_cal_en ? 0 : sm(c.dark_offset));
        return v < 0 ? 12'h000 : (v > 4095 ? 12'hFFF : 12'(v));
    endfunction
    // Derived outputs may lag the field by a cycle, so wait for two quiet samples
    property p_win_sel;
        $stable(cfg.sw_mode) [*2] |-> win_sel == sel_of(cfg.sw_mode);
    endproperty
    a_win_sel: assert property (p_win_sel) else $error("window select decode wrong");
    property p_win_excl;
        win_sel.ae_excl || win_sel.wb_excl || win_sel.lut_excl |-> win_sel != 6'h00 ##0
            (!win_sel.ae_excl || win_sel.ae_use) && (!win_sel.lut_excl || win_sel.lut_use)
            && (!win_sel.wb_excl || win_sel.wb_use);
    endproperty
    a_win_excl: assert property (p_win_excl) else $error("exclude without window");
    property p_subsample;
        $stable(cfg.subsample) [*2] |-> {decim.sub_y, decim.sub_x} == cfg.subsample;
    endproperty
    a_subsample: assert property (p_subsample) else $error("subsample mode wrong");
    property p_average;
        $stable(cfg.average) [*2] |-> {decim.avg_y, decim.avg_x} == cfg.average;
    endproperty
    a_average: assert property (p_average) else $error("average mode wrong");
    property p_analog;
        $stable(cfg.analog_gain) [*2] |-> analog_gain_q8 == q8_of(cfg.analog_gain);
    endproperty
    a_analog: assert property (p_analog) else $error("analog gain wrong");
    property p_dgain;
        $stable(cfg.digital_gain) [*2] |-> digital_gain_valid == (cfg.digital_gain >= 14'h0400)
            && digital_gain_steps == (cfg.digital_gain >= 14'h0400 ?
            cfg.digital_gain - 14'h0400 : 14'h0);
    endproperty
    a_dgain: assert property (p_dgain) else $error("digital gain wrong");
    property p_pix;
        $stable(cfg) [*2] ##0 pix_valid |=>
            pix_out_valid && pix_out == pix_of($past(pix_in), $past(cfg));
    endproperty
    a_pix: assert property (p_pix) else $error("pixel correction wrong");
    property p_pix_idle;
        !pix_valid |=> !pix_out_valid;
    endproperty
    a_pix_idle: assert property (p_pix_idle) else $error("spurious pixel");
endmodule

// File: dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pix_valid = 1'b0;
    logic [11:0] pix_in = 12'h0;
    logic pix_out_valid;
    logic [11:0] pix_out;
    pix_regs_pkg::cfg_type cfg;
    pix_regs_pkg::win_sel_type win_sel;
    pix_regs_pkg::decim_type decim;
    logic [9:0] analog_gain_q8;
    logic digital_gain_valid;
    logic [13:0] digital_gain_steps;
    int fails = 0;
    int compares = 0;
    logic [11:0] addrs [14] = '{12'h000, 12'h004, 12'h010, 12'h014, 12'h018, 12'h01C, 12'h020,
        12'h438, 12'h43C, 12'h73C, 12'h748, 12'h754, 12'h758, 12'h75C};
    int widths [14] = '{12, 12, 13, 13, 13, 13, 4, 14, 10, 2, 2, 2, 1, 10};
    logic [31:0] resets [14] = '{32'h0, 32'h2, 32'h0, 32'h2, 32'h0, 32'h8, 32'h0, 32'h400,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [9:0] gains [4] = '{10'h100, 10'h143, 10'h1DF, 10'h32B};
    logic [13:0] dg [3] = '{14'h03FF, 14'h0400, 14'h3FFF};
    image_window_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pix_valid(pix_valid),
        .pix_in(pix_in), .pix_out_valid(pix_out_valid), .pix_out(pix_out), .cfg(cfg),
        .win_sel(win_sel), .decim(decim), .analog_gain_q8(analog_gain_q8),
        .digital_gain_valid(digital_gain_valid), .digital_gain_steps(digital_gain_steps));
    always #25 hclk = ~hclk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(what, exp, r);
        chk("response", 32'h0, 32'(hresp));
    endtask
    // Write, then a read of the same word issued in the write's data phase
    task automatic wr_rd_chk(input string what, input logic [11:0] a, input logic [31:0] d,
                             input logic [31:0] exp);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hwrite <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        chk(what, exp, hrdata);
    endtask
    task automatic check_resets;
        for (int i = 0; i < 14; i++) rd_chk("reset value", addrs[i], resets[i]);
        $display("test reset values done");
    endtask
    task automatic pix(input logic [11:0] in, input logic [11:0] exp);
        @(posedge hclk);
        pix_valid <= 1'b1;
        pix_in <= in;
        @(posedge hclk);
        pix_valid <= 1'b0;
        #1;
        chk("pixel valid", 32'h1, 32'(pix_out_valid));
        chk("pixel", 32'(exp), 32'(pix_out));
    endtask
    task automatic report_and_stop;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        check_resets();
        for (int i = 0; i < 14; i++) begin
            wr(addrs[i], 32'hFFFFFFFF);
            rd_chk("field width", addrs[i], (32'h1 << widths[i]) - 32'h1);
        end
        wr(12'h008, 32'hFFFFFFFF);
        rd_chk("unmapped", 12'h008, 32'h0);
        $display("test field widths done");
        wr_rd_chk("readout offset", pix_regs_pkg::OFF_VWIN_OFFSET, 32'hFFFFF00A, 32'h00A);
        wr_rd_chk("readout size", pix_regs_pkg::OFF_VWIN_SIZE, 32'h3FE, 32'h3FE);
        wr_rd_chk("window h offset", pix_regs_pkg::OFF_SWIN_HOFFSET, 32'h040, 32'h040);
        wr_rd_chk("window h size", pix_regs_pkg::OFF_SWIN_HSIZE, 32'h080, 32'h080);
        wr_rd_chk("window v offset", pix_regs_pkg::OFF_SWIN_VOFFSET, 32'h010, 32'h010);
        wr_rd_chk("window v size", pix_regs_pkg::OFF_SWIN_VSIZE, 32'h020, 32'h020);
        @(posedge hclk);
        chk("cfg readout offset", 32'h00A, 32'(cfg.v_offset));
        chk("cfg readout size", 32'h3FE, 32'(cfg.v_size));
        chk("cfg window h offset", 32'h040, 32'(cfg.sw_hoffset));
        chk("cfg window h size", 32'h080, 32'(cfg.sw_hsize));
        chk("cfg window v offset", 32'h010, 32'(cfg.sw_voffset));
        chk("cfg window v size", 32'h020, 32'(cfg.sw_vsize));
        $display("test window setup done");
        for (int m = 0; m < 16; m++) begin
            wr(pix_regs_pkg::OFF_SWIN_MODE, 32'(m));
            rd_chk("window mode", pix_regs_pkg::OFF_SWIN_MODE, 32'(m));
        end
        for (int c = 0; c < 4; c++) begin
            wr(pix_regs_pkg::OFF_AGAIN, 32'(c));
            wr(pix_regs_pkg::OFF_SUBSAMPLE, 32'(c));
            wr(pix_regs_pkg::OFF_AVERAGE, 32'(3 - c));
            rd_chk("average readback", pix_regs_pkg::OFF_AVERAGE, 32'(3 - c));
            chk("analog gain", 32'(gains[c]), 32'(analog_gain_q8));
            chk("subsample", 32'(c), 32'({decim.sub_y, decim.sub_x}));
            chk("average", 32'(3 - c), 32'({decim.avg_y, decim.avg_x}));
        end
        for (int i = 0; i < 3; i++) begin
            wr(pix_regs_pkg::OFF_DGAIN, 32'(dg[i]));
            rd_chk("gain readback", pix_regs_pkg::OFF_DGAIN, 32'(dg[i]));
            chk("gain valid", 32'(i > 0), 32'(digital_gain_valid));
            chk("gain steps", i > 0 ? 32'(dg[i] - 14'h0400) : 32'h0,
                32'(digital_gain_steps));
        end
        $display("test modes and gains done");
        wr(pix_regs_pkg::OFF_DARK_CAL, 32'h1);
        wr(pix_regs_pkg::OFF_DARK_OFFSET, 32'h1FF);
        wr(pix_regs_pkg::OFF_DOFFSET, 32'h0);
        pix(12'h064, 12'h064);
        wr(pix_regs_pkg::OFF_DARK_CAL, 32'h0);
        pix(12'h064, 12'h263);
        wr(pix_regs_pkg::OFF_DOFFSET, 32'h205);
        pix(12'h064, 12'h25E);
        pix(12'hFFF, 12'hFFF);
        wr(pix_regs_pkg::OFF_DARK_OFFSET, 32'h3FF);
        pix(12'h00A, 12'h000);
        pix(12'h300, 12'h0FC);
        $display("test pixel correction done");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        check_resets();
        report_and_stop();
    end
endmodule
bind image_window_regs image_window_regs_sva i_sva (.hclk(hclk), .hresetn(hresetn),
    .pix_valid(pix_valid), .pix_in(pix_in), .pix_out_valid(pix_out_valid),
    .pix_out(pix_out), .cfg(cfg), .win_sel(win_sel), .decim(decim),
    .analog_gain_q8(analog_gain_q8), .digital_gain_valid(digital_gain_valid),
    .digital_gain_steps(digital_gain_steps));
